// ---- hw/hcr_pkg.sv ----
// Package: register map, field layout, reset values and timing for the holdover config block
package hcr_pkg;
  // Register offsets (byte addresses on the processor port)
  localparam logic [9:0] OFS_NOM_LOW = 10'h094;
  localparam logic [9:0] OFS_NOM_MID = 10'h095;
  localparam logic [9:0] OFS_NOM_TOP = 10'h096;
  localparam logic [9:0] OFS_ADJ_LOW = 10'h097;
  localparam logic [9:0] OFS_ADJ_HIGH = 10'h098;
  localparam logic [9:0] OFS_HO_BYTE0 = 10'h09C;
  localparam logic [9:0] OFS_HO_BYTE1 = 10'h09D;
  localparam logic [9:0] OFS_HO_BYTE2 = 10'h09E;
  localparam logic [9:0] OFS_HO_BYTE3 = 10'h09F;
  localparam logic [9:0] OFS_PB_DELAY = 10'h24A;

  // Field widths and positions
  localparam int NOM_W = 17;
  localparam int ADJ_W = 9;
  localparam int HO_W = 32;
  localparam int TOP_BIT_POS = 0;
  localparam int PB_CODE_W = 4;

  // Reset values
  localparam logic [NOM_W-1:0] NOM_RESET = 17'h00000;
  localparam logic [ADJ_W-1:0] ADJ_RESET = 9'h000;
  localparam logic [HO_W-1:0] HO_RESET = 32'h00000000;
  localparam logic [PB_CODE_W-1:0] PB_RESET = 4'h6;

  // Build-out delay codes and holdover selection
  localparam logic [PB_CODE_W-1:0] PB_CODE_LONG = 4'h6;
  localparam logic [PB_CODE_W-1:0] PB_CODE_SHORT = 4'hA;
  localparam logic [1:0] HO_SEL_MANUAL = 2'h1;

  // Nominal frequency arithmetic: base 204.8 MHz, step 500 Hz
  localparam int NOM_BASE_HZ = 204_800_000;
  localparam int NOM_STEP_HZ = 500;
  localparam int NOM_HZ_W = 29;

  // Timing: clock rate and build-out delays
  localparam int CLK_HZ = 40_000_000;
  localparam int PB_LONG_MS = 2000;
  localparam int PB_SHORT_MS = 10;
  localparam int PB_LONG_CYC = PB_LONG_MS * (CLK_HZ / 1000);
  localparam int PB_SHORT_CYC = PB_SHORT_MS * (CLK_HZ / 1000);
  localparam int PB_CNT_W = 27;

  // Processor port request
  typedef struct packed {
    logic [9:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } hcr_req_t;

  // Build-out timer states
  typedef enum logic {PB_IDLE, PB_WAIT} hcr_pb_state_t;
endpackage

// ---- hw/hcr_regs.sv ----
// Holdover and master-clock configuration registers with phase build-out delay timer
`timescale 1ns/1ps
module hcr_regs #(
  parameter int PB_LONG_CYCLES = hcr_pkg::PB_LONG_CYC,
  parameter int PB_SHORT_CYCLES = hcr_pkg::PB_SHORT_CYC
) (
  // Clock and reset
  input wire logic MCLK,
  input wire logic SYS_RST,
  // Processor register port
  input wire hcr_pkg::hcr_req_t REG_REQ,
  output logic [7:0] REG_RDATA,
  // DPLL side
  input wire logic [1:0] HOLDOVER_SELECT,
  input wire logic INPUT_SWITCH,
  output logic [hcr_pkg::HO_W-1:0] MANUAL_HOLDOVER_DPLL_CURRENT_A,
  output logic MANUAL_HOLDOVER_ACTIVE,
  output logic BUILDOUT_START,
  output logic [hcr_pkg::PB_CODE_W-1:0] PHASE_BUILDOUT_DELAY,
  // Input block side
  output logic [hcr_pkg::NOM_W-1:0] INPUT_BLOCK_NOMINAL_DPLL_CURRENT_A,
  output logic [hcr_pkg::NOM_HZ_W-1:0] INPUT_NOMINAL_HZ,
  output logic [hcr_pkg::ADJ_W-1:0] MCLK_ADJUST_COUNT
);

  // One less than the delay, since the start pulse itself is registered
  localparam logic [hcr_pkg::PB_CNT_W-1:0] LONG_LOAD = hcr_pkg::PB_CNT_W'(PB_LONG_CYCLES - 1);
  localparam logic [hcr_pkg::PB_CNT_W-1:0] SHORT_LOAD = hcr_pkg::PB_CNT_W'(PB_SHORT_CYCLES - 1);

  logic wr;
  logic rd;
  logic [9:0] addr;
  logic [7:0] wdata;
  logic [15:0] nom_stage;
  logic [7:0] adj_stage;
  logic [23:0] ho_stage;
  logic [15:0] nom_snap;
  logic [7:0] adj_snap;
  logic [23:0] ho_snap;
  logic [7:0] next_rdata;
  logic [hcr_pkg::PB_CNT_W-1:0] pb_count;
  hcr_pkg::hcr_pb_state_t pb_state;
  logic signed [hcr_pkg::NOM_HZ_W-1:0] next_nom_hz;

  assign wr = REG_REQ.wr;
  assign rd = REG_REQ.rd;
  assign addr = REG_REQ.addr;
  assign wdata = REG_REQ.wdata;

  // Lower bytes are staged so the live field never shows a half-written value
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      nom_stage <= 16'h0000;
      adj_stage <= 8'h00;
      ho_stage <= 24'h000000;
    end else if (wr) begin
      if (addr == hcr_pkg::OFS_NOM_LOW) nom_stage[7:0] <= wdata;
      if (addr == hcr_pkg::OFS_NOM_MID) nom_stage[15:8] <= wdata;
      if (addr == hcr_pkg::OFS_ADJ_LOW) adj_stage <= wdata;
      if (addr == hcr_pkg::OFS_HO_BYTE0) ho_stage[7:0] <= wdata;
      if (addr == hcr_pkg::OFS_HO_BYTE1) ho_stage[15:8] <= wdata;
      if (addr == hcr_pkg::OFS_HO_BYTE2) ho_stage[23:16] <= wdata;
    end
  end

  // Writing the top byte of a field commits the whole field in one edge
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      INPUT_BLOCK_NOMINAL_DPLL_CURRENT_A <= hcr_pkg::NOM_RESET;
      MCLK_ADJUST_COUNT <= hcr_pkg::ADJ_RESET;
      MANUAL_HOLDOVER_DPLL_CURRENT_A <= hcr_pkg::HO_RESET;
      PHASE_BUILDOUT_DELAY <= hcr_pkg::PB_RESET;
    end else if (wr) begin
      if (addr == hcr_pkg::OFS_NOM_TOP) begin
        INPUT_BLOCK_NOMINAL_DPLL_CURRENT_A <= {wdata[hcr_pkg::TOP_BIT_POS], nom_stage};
      end
      if (addr == hcr_pkg::OFS_ADJ_HIGH) begin
        MCLK_ADJUST_COUNT <= {wdata[hcr_pkg::TOP_BIT_POS], adj_stage};
      end
      if (addr == hcr_pkg::OFS_HO_BYTE3) begin
        MANUAL_HOLDOVER_DPLL_CURRENT_A <= {wdata, ho_stage};
      end
      if (addr == hcr_pkg::OFS_PB_DELAY) begin
        PHASE_BUILDOUT_DELAY <= wdata[hcr_pkg::PB_CODE_W-1:0];
      end
    end
  end

  // Reading the low byte freezes the upper bytes for the rest of the sequence
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      nom_snap <= 16'h0000;
      adj_snap <= 8'h00;
      ho_snap <= 24'h000000;
    end else if (rd) begin
      if (addr == hcr_pkg::OFS_NOM_LOW) begin
        nom_snap <= {7'h00, INPUT_BLOCK_NOMINAL_DPLL_CURRENT_A[16:8]};
      end
      if (addr == hcr_pkg::OFS_ADJ_LOW) adj_snap <= {7'h00, MCLK_ADJUST_COUNT[8]};
      if (addr == hcr_pkg::OFS_HO_BYTE0) ho_snap <= MANUAL_HOLDOVER_DPLL_CURRENT_A[31:8];
    end
  end

  // Read mux; reserved bits and unmapped addresses read as zero
  always_comb begin
    next_rdata = 8'h00;
    unique case (addr)
      hcr_pkg::OFS_NOM_LOW: next_rdata = INPUT_BLOCK_NOMINAL_DPLL_CURRENT_A[7:0];
      hcr_pkg::OFS_NOM_MID: next_rdata = nom_snap[7:0];
      hcr_pkg::OFS_NOM_TOP: next_rdata = nom_snap[15:8];
      hcr_pkg::OFS_ADJ_LOW: next_rdata = MCLK_ADJUST_COUNT[7:0];
      hcr_pkg::OFS_ADJ_HIGH: next_rdata = adj_snap;
      hcr_pkg::OFS_HO_BYTE0: next_rdata = MANUAL_HOLDOVER_DPLL_CURRENT_A[7:0];
      hcr_pkg::OFS_HO_BYTE1: next_rdata = ho_snap[7:0];
      hcr_pkg::OFS_HO_BYTE2: next_rdata = ho_snap[15:8];
      hcr_pkg::OFS_HO_BYTE3: next_rdata = ho_snap[23:16];
      hcr_pkg::OFS_PB_DELAY: next_rdata = {4'h0, PHASE_BUILDOUT_DELAY};
      default: next_rdata = 8'h00;
    endcase
  end

  // Read data is registered and holds until the next read
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      REG_RDATA <= 8'h00;
    end else if (rd) begin
      REG_RDATA <= next_rdata;
    end
  end

  // Input block frequency in Hz; value is signed, so positive codes lower the rate
  assign next_nom_hz = hcr_pkg::NOM_HZ_W'(hcr_pkg::NOM_BASE_HZ)
    - hcr_pkg::NOM_HZ_W'(signed'(INPUT_BLOCK_NOMINAL_DPLL_CURRENT_A) * hcr_pkg::NOM_STEP_HZ);

  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      INPUT_NOMINAL_HZ <= hcr_pkg::NOM_HZ_W'(hcr_pkg::NOM_BASE_HZ);
    end else begin
      INPUT_NOMINAL_HZ <= next_nom_hz;
    end
  end

  // Manual holdover qualifier; scaling to ppm is left to the DPLL datapath
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      MANUAL_HOLDOVER_ACTIVE <= 1'b0;
    end else begin
      MANUAL_HOLDOVER_ACTIVE <= (HOLDOVER_SELECT == hcr_pkg::HO_SEL_MANUAL);
    end
  end

  // Build-out delay timer; a new switch restarts the wait. Undefined codes
  // take the long delay, the safer choice for a jittery input.
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      pb_state <= hcr_pkg::PB_IDLE;
      pb_count <= '0;
      BUILDOUT_START <= 1'b0;
    end else begin
      BUILDOUT_START <= 1'b0;
      if (INPUT_SWITCH) begin
        pb_state <= hcr_pkg::PB_WAIT;
        if (PHASE_BUILDOUT_DELAY == hcr_pkg::PB_CODE_SHORT) begin
          pb_count <= SHORT_LOAD;
        end else begin
          pb_count <= LONG_LOAD;
        end
      end else begin
        unique case (pb_state)
          hcr_pkg::PB_IDLE: pb_count <= '0;
          hcr_pkg::PB_WAIT: begin
            if (pb_count <= 1) begin
              pb_state <= hcr_pkg::PB_IDLE;
              BUILDOUT_START <= 1'b1;
            end else begin
              pb_count <= pb_count - 1'b1;
            end
          end
        endcase
      end
    end
  end

endmodule

// ---- tb/hcr_regs_sva.sv ----
// Checker for the holdover config register block
`timescale 1ns/1ps
module hcr_regs_sva #(
  parameter int PB_LONG_CYCLES = 20,
  parameter int PB_SHORT_CYCLES = 5
) (
  // Clock and reset
  input wire logic MCLK,
  input wire logic SYS_RST,
  // Watched ports
  input wire hcr_pkg::hcr_req_t REG_REQ,
  input wire logic [1:0] HOLDOVER_SELECT,
  input wire logic INPUT_SWITCH,
  input wire logic [31:0] MANUAL_HOLDOVER_DPLL_CURRENT_A,
  input wire logic MANUAL_HOLDOVER_ACTIVE,
  input wire logic BUILDOUT_START,
  input wire logic [3:0] PHASE_BUILDOUT_DELAY,
  input wire logic [16:0] INPUT_BLOCK_NOMINAL_DPLL_CURRENT_A,
  input wire logic [28:0] INPUT_NOMINAL_HZ
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (SYS_RST);
  // Top-byte writes, the only moments a field may commit
  wire ho_top = REG_REQ.wr && REG_REQ.addr == hcr_pkg::OFS_HO_BYTE3;
  wire nom_top = REG_REQ.wr && REG_REQ.addr == hcr_pkg::OFS_NOM_TOP;
  // Reset term guards the first edge, where the flag is still at its reset value
  a_select_manual: assert property (MANUAL_HOLDOVER_ACTIVE ==
    (!$past(SYS_RST) && $past(HOLDOVER_SELECT) == 2'h1)) else $error("holdover flag wrong");
  a_nominal_hz: assert property (INPUT_NOMINAL_HZ == 29'(204800000 -
    500 * $signed($past(INPUT_BLOCK_NOMINAL_DPLL_CURRENT_A)))) else $error("nominal Hz wrong");
  a_long_delay: assert property (INPUT_SWITCH && PHASE_BUILDOUT_DELAY != 4'hA
    |-> ##PB_LONG_CYCLES BUILDOUT_START) else $error("long delay wrong");
  a_short_delay: assert property (INPUT_SWITCH && PHASE_BUILDOUT_DELAY == 4'hA
    |-> ##PB_SHORT_CYCLES BUILDOUT_START) else $error("short delay wrong");
  a_start_cause: assert property (BUILDOUT_START |-> $past(INPUT_SWITCH, PB_SHORT_CYCLES)
    || $past(INPUT_SWITCH, PB_LONG_CYCLES)) else $error("start without switch");
  a_ho_commit: assert property ($changed(MANUAL_HOLDOVER_DPLL_CURRENT_A) |-> $past(ho_top))
    else $error("holdover changed early");
  a_ho_top: assert property (ho_top |=> MANUAL_HOLDOVER_DPLL_CURRENT_A[31:24] == $past(REG_REQ.wdata))
    else $error("holdover top byte wrong");
  a_nom_sign: assert property (nom_top |=> INPUT_BLOCK_NOMINAL_DPLL_CURRENT_A[16] ==
    $past(REG_REQ.wdata[0])) else $error("nominal top bit wrong");
endmodule
bind hcr_regs hcr_regs_sva #(.PB_LONG_CYCLES(PB_LONG_CYCLES), .PB_SHORT_CYCLES(PB_SHORT_CYCLES))
  i_hcr_regs_sva (.MCLK(MCLK), .SYS_RST(SYS_RST), .REG_REQ(REG_REQ),
  .HOLDOVER_SELECT(HOLDOVER_SELECT), .INPUT_SWITCH(INPUT_SWITCH),
  .MANUAL_HOLDOVER_DPLL_CURRENT_A(MANUAL_HOLDOVER_DPLL_CURRENT_A), .MANUAL_HOLDOVER_ACTIVE(MANUAL_HOLDOVER_ACTIVE),
  .BUILDOUT_START(BUILDOUT_START), .PHASE_BUILDOUT_DELAY(PHASE_BUILDOUT_DELAY),
  .INPUT_BLOCK_NOMINAL_DPLL_CURRENT_A(INPUT_BLOCK_NOMINAL_DPLL_CURRENT_A), .INPUT_NOMINAL_HZ(INPUT_NOMINAL_HZ));

// ---- tb/hcr_regs_tb_top.sv ----
// Self-checking bench for the holdover config register block
`timescale 1ns/1ps
module hcr_regs_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  hcr_pkg::hcr_req_t req = '0;
  logic [1:0] sel = 2'h0;
  logic sw = 1'b0;
  logic [7:0] rdata;
  logic [31:0] hof;
  logic act;
  logic start;
  logic [3:0] pbd;
  logic [16:0] nom;
  logic [28:0] hz;
  logic [8:0] adj;
  int bad_count = 0;
  int comparisons = 0;
  int cycles = 0;
  // Short delays keep the run brief; expectations below use the same figures
  hcr_regs #(.PB_LONG_CYCLES(20), .PB_SHORT_CYCLES(5)) i_hcr_regs (.MCLK(clk), .SYS_RST(rst),
    .REG_REQ(req), .REG_RDATA(rdata), .HOLDOVER_SELECT(sel), .INPUT_SWITCH(sw),
    .MANUAL_HOLDOVER_DPLL_CURRENT_A(hof), .MANUAL_HOLDOVER_ACTIVE(act), .BUILDOUT_START(start),
    .PHASE_BUILDOUT_DELAY(pbd), .INPUT_BLOCK_NOMINAL_DPLL_CURRENT_A(nom), .INPUT_NOMINAL_HZ(hz),
    .MCLK_ADJUST_COUNT(adj));
  // 40 MHz clock and a hang limit
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      bad_count++;
      stop_test();
    end
  end
  task automatic stop_test;
    if (bad_count == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One-byte bus cycles; each leaves one idle cycle so strobes never toggle twice at once
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    req.addr = a;
    req.wdata = d;
    req.wr = 1'b1;
    @(posedge clk);
    #1;
    req.wr = 1'b0;
  endtask
  task automatic rd(input logic [9:0] a, input logic [7:0] exp);
    @(posedge clk);
    #1;
    req.addr = a;
    req.rd = 1'b1;
    @(posedge clk);
    #1;
    req.rd = 1'b0;
    chk(rdata, exp);
  endtask
  // Reset values; 0x99 to 0x9B are unmapped and read zero too
  task automatic t_reset;
    for (logic [9:0] a = 10'h094; a < 10'h0A0; a++) rd(a, 8'h00);
    rd(hcr_pkg::OFS_PB_DELAY, 8'h06);
    chk(hz, 29'h0C350000);
  endtask
  // Holdover commits only on its top byte, then reads back coherently
  task automatic t_holdover;
    wr(10'h205, 8'h01);
    wr(10'h09C, 8'h44);
    wr(10'h09D, 8'h33);
    wr(10'h09E, 8'h22);
    chk(hof, 32'h00000000);
    wr(10'h09F, 8'h11);
    chk(hof, 32'h11223344);
    rd(10'h09C, 8'h44);
    rd(10'h09D, 8'h33);
    rd(10'h09E, 8'h22);
    rd(10'h09F, 8'h11);
  endtask
  // Negative nominal code (208 MHz) and an all-ones adjust count
  task automatic t_nominal;
    wr(10'h094, 8'h00);
    wr(10'h095, 8'hE7);
    wr(10'h096, 8'h01);
    chk(nom, 32'h0001E700);
    @(posedge clk);
    #1;
    chk(hz, 29'h0C65D400);
    wr(10'h097, 8'hFF);
    wr(10'h098, 8'hFF);
    chk(adj, 32'h000001FF);
    rd(10'h097, 8'hFF);
    rd(10'h098, 8'h01);
  endtask
  task automatic t_select;
    for (int s = 0; s < 4; s++) begin
      sel = 2'(s);
      @(posedge clk);
      #1;
      chk(act, 32'(s == 1));
    end
  endtask
  // Counts cycles from the switch to the build-out start pulse
  task automatic t_pb(input logic [3:0] code, input int load);
    int n;
    wr(hcr_pkg::OFS_PB_DELAY, {4'h0, code});
    chk(pbd, 32'(code));
    sw = 1'b1;
    @(posedge clk);
    #1;
    sw = 1'b0;
    n = 1;
    while (start !== 1'b1 && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(n, load);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    #1;
    rst = 1'b0;
    t_reset();
    t_holdover();
    t_nominal();
    t_select();
    t_pb(4'h6, 20);
    t_pb(4'hA, 5);
    t_pb(4'h3, 20);
    stop_test();
  end
endmodule
